// File: pkg/gpmd_pkg.sv
package gpmd_pkg;

  // Bus and port widths.
  localparam int unsigned GPMD_PINS   = 8;
  localparam int unsigned GPMD_ADDR_W = 12;
  localparam int unsigned GPMD_DATA_W = 32;

  // The masked data window spans 256 words; address bits 9..2 form the mask.
  localparam int unsigned GPMD_MASK_LSB = 2;
  localparam int unsigned GPMD_MASK_MSB = 9;
  localparam logic [1:0]  GPMD_DATA_WIN = 2'h0;

  // Register offsets in bytes.
  localparam logic [GPMD_ADDR_W-1:0] GPMD_OFF_DIR   = 12'h400;
  localparam logic [GPMD_ADDR_W-1:0] GPMD_OFF_IS    = 12'h404;
  localparam logic [GPMD_ADDR_W-1:0] GPMD_OFF_IBE   = 12'h408;
  localparam logic [GPMD_ADDR_W-1:0] GPMD_OFF_IEV   = 12'h40C;
  localparam logic [GPMD_ADDR_W-1:0] GPMD_OFF_IM    = 12'h410;
  localparam logic [GPMD_ADDR_W-1:0] GPMD_OFF_RIS   = 12'h414;
  localparam logic [GPMD_ADDR_W-1:0] GPMD_OFF_MIS   = 12'h418;
  localparam logic [GPMD_ADDR_W-1:0] GPMD_OFF_ICR   = 12'h41C;
  localparam logic [GPMD_ADDR_W-1:0] GPMD_OFF_AFSEL = 12'h420;
  localparam logic [GPMD_ADDR_W-1:0] GPMD_OFF_DR2   = 12'h500;
  localparam logic [GPMD_ADDR_W-1:0] GPMD_OFF_DR4   = 12'h504;
  localparam logic [GPMD_ADDR_W-1:0] GPMD_OFF_DR8   = 12'h508;
  localparam logic [GPMD_ADDR_W-1:0] GPMD_OFF_ODR   = 12'h50C;
  localparam logic [GPMD_ADDR_W-1:0] GPMD_OFF_PUR   = 12'h510;
  localparam logic [GPMD_ADDR_W-1:0] GPMD_OFF_PDR   = 12'h514;
  localparam logic [GPMD_ADDR_W-1:0] GPMD_OFF_SLR   = 12'h518;
  localparam logic [GPMD_ADDR_W-1:0] GPMD_OFF_DEN   = 12'h51C;
  localparam logic [GPMD_ADDR_W-1:0] GPMD_OFF_LOCK  = 12'h520;
  localparam logic [GPMD_ADDR_W-1:0] GPMD_OFF_CR    = 12'h524;
  localparam logic [GPMD_ADDR_W-1:0] GPMD_OFF_PID0  = 12'hFD0;
  localparam logic [GPMD_ADDR_W-1:0] GPMD_OFF_CID0  = 12'hFF0;
  localparam int unsigned GPMD_PID_NUM = 8;
  localparam int unsigned GPMD_CID_NUM = 4;

  // Reset values of the ordinary pins.
  localparam logic [7:0] GPMD_RST_ZERO = 8'h00;
  localparam logic [7:0] GPMD_RST_ONES = 8'hFF;

  // Default instance: the debug pin sits at bit 7, the ADC trigger at bit 4.
  localparam logic [7:0] GPMD_PROTECT_DEFAULT  = 8'h80;
  localparam int unsigned GPMD_ADC_TRIG_DEFAULT = 4;

  // Unlock key; the value is arbitrary.
  localparam logic [31:0] GPMD_LOCK_KEY_DEFAULT = 32'h5A5AC3C3;

  // Identification bytes; the values are arbitrary.
  localparam logic [7:0] GPMD_PERIPH_ID [GPMD_PID_NUM] =
    '{8'h11, 8'h22, 8'h33, 8'h44, 8'h55, 8'h66, 8'h77, 8'h88};
  localparam logic [7:0] GPMD_CELL_ID [GPMD_CID_NUM] =
    '{8'hA1, 8'hB2, 8'hC3, 8'hD4};

endpackage

// File: src/gpmd_pin_sync.sv
`timescale 1ns/1ps
module gpmd_pin_sync
#(
  parameter int unsigned WIDTH = 8
)
(
  input  wire logic             REF_CLK_IN,
  input  wire logic             RESET_IN,
  input  wire logic [WIDTH-1:0] RAW_IN,
  output logic      [WIDTH-1:0] LEVEL_OUT,
  output logic      [WIDTH-1:0] RISE_OUT,
  output logic      [WIDTH-1:0] FALL_OUT
);

  logic [WIDTH-1:0] meta;
  logic [WIDTH-1:0] stable;
  logic [WIDTH-1:0] prev;
  logic             armed;

  // Two-stage synchroniser and history stage; they run through reset so the
  // history matches the pin when reset lifts and a pin that idles high
  // shows no false rising edge.
  always_ff @(posedge REF_CLK_IN)
  begin
    meta   <= RAW_IN;
    stable <= meta;
    prev   <= stable;
  end

  // Edges stay hidden while reset holds, when the stages may still carry
  // unsettled start-up values.
  always_ff @(posedge REF_CLK_IN)
  begin
    if (RESET_IN)
      armed <= 1'b0;
    else
      armed <= 1'b1;
  end

  // Edges are taken only from the settled stages, never from the first.
  assign LEVEL_OUT = stable;
  assign RISE_OUT  = stable & ~prev & {WIDTH{armed}};
  assign FALL_OUT  = ~stable & prev & {WIDTH{armed}};

endmodule

// File: src/gpmd_port.sv
`timescale 1ns/1ps
// Function
// RULE_01: After reset ordinary pins float with alt, enable and pulls cleared.
// RULE_02: After reset protected debug pins set alt select, enable, pull-up.
// RULE_03: Any reset returns both pin groups to their default configuration.
// RULE_04: Direction 0 makes a pin input; its data bit follows the pin.
// RULE_05: Direction 1 makes a pin output driven from its data bit.
// RULE_06: Data register spans 256 words; address bits 9..2 mask the bits.
// RULE_07: Data writes change only bits whose address mask bit is 1.
// RULE_08: Data reads return unmasked bits and zero for masked bits.
// RULE_09: All enabled pin interrupts merge into one port interrupt line.
// RULE_10: An edge interrupt stays latched until software clears it.
// RULE_11: Level sources hold their level until the interrupt is serviced.
// RULE_12: Per pin: edge or level, single or both edges, and polarity.
// RULE_13: A per-pin mask bit gates the pin onto the port interrupt.
// RULE_14: Raw status ignores the mask; masked status shows gated conditions.
// RULE_15: Writing 1 to the clear register clears a latched edge; 0 nothing.
// RULE_16: An unmasked ADC trigger pin also pulses the ADC trigger output.
// RULE_17: Software masks interrupts before changing trigger settings.
// RULE_18: Alternate select hands the pin to the peripheral, else data regs.
// RULE_19: Protected alt-select bits change only when unlocked and committed.
// RULE_20: Pad settings give drive, open drain, pulls, slew and enable.
// RULE_21: Read-only identification registers let software detect the block.
// RULE_22: Both-edge mode fires on either edge and overrides polarity.
// RULE_23: Pin inputs are synchronised before capture and edge detection.
module gpmd_port
  import gpmd_pkg::*;
#(
  parameter logic [GPMD_PINS-1:0] PROTECT_MASK = GPMD_PROTECT_DEFAULT,
  parameter int unsigned          ADC_TRIG_BIT = GPMD_ADC_TRIG_DEFAULT,
  parameter logic [31:0]          LOCK_KEY     = GPMD_LOCK_KEY_DEFAULT
)
(
  input  wire logic                   REF_CLK_IN,
  input  wire logic                   RESET_IN,
  input  wire logic [GPMD_ADDR_W-1:0] REG_ADDR_IN,
  input  wire logic [GPMD_DATA_W-1:0] REG_WDATA_IN,
  input  wire logic                   REG_WR_IN,
  input  wire logic                   REG_RD_IN,
  output logic      [GPMD_DATA_W-1:0] REG_RDATA_OUT,
  input  wire logic [GPMD_PINS-1:0]   PIN_IN,
  output logic      [GPMD_PINS-1:0]   PIN_OUT,
  output logic      [GPMD_PINS-1:0]   PIN_OE_OUT,
  input  wire logic [GPMD_PINS-1:0]   ALT_OUT_IN,
  input  wire logic [GPMD_PINS-1:0]   ALT_OE_IN,
  output logic      [GPMD_PINS-1:0]   ALT_IN_OUT,
  output logic      [GPMD_PINS-1:0]   PULL_UP_OUT,
  output logic      [GPMD_PINS-1:0]   PULL_DOWN_OUT,
  output logic      [GPMD_PINS-1:0]   DIGITAL_EN_OUT,
  output logic      [GPMD_PINS-1:0]   DRIVE_2MA_OUT,
  output logic      [GPMD_PINS-1:0]   DRIVE_4MA_OUT,
  output logic      [GPMD_PINS-1:0]   DRIVE_8MA_OUT,
  output logic      [GPMD_PINS-1:0]   SLEW_CTRL_OUT,
  output logic      [GPMD_PINS-1:0]   OPEN_DRAIN_OUT,
  output logic                        IRQ_OUT,
  output logic                        ADC_TRIG_OUT
);

  localparam int unsigned N = GPMD_PINS;
  localparam int unsigned PAD = GPMD_DATA_W - N;

  // Word-aligned address compare used by every register decode except the data window and ID ranges.
  function automatic logic word_hit(input logic [GPMD_ADDR_W-1:0] addr,
                                    input logic [GPMD_ADDR_W-1:0] off);
    word_hit = (addr[GPMD_ADDR_W-1:2] == off[GPMD_ADDR_W-1:2]);
  endfunction

  // Replaces the bits selected by sel with the matching bits of val.
  function automatic logic [N-1:0] merge(input logic [N-1:0] old,
                                         input logic [N-1:0] val,
                                         input logic [N-1:0] sel);
    merge = (old & ~sel) | (val & sel);
  endfunction

  logic [N-1:0] masked_data_reg;
  logic [N-1:0] direction_bits;
  logic [N-1:0] irq_sense_select;
  logic [N-1:0] irq_both_edge_select;
  logic [N-1:0] irq_polarity_select;
  logic [N-1:0] irq_mask_bits;
  logic [N-1:0] edge_latch;
  logic [N-1:0] alt_function_select;
  logic [N-1:0] drive_2ma_select;
  logic [N-1:0] drive_4ma_select;
  logic [N-1:0] drive_8ma_select;
  logic [N-1:0] open_drain_select;
  logic [N-1:0] pull_up_select;
  logic [N-1:0] pull_down_select;
  logic [N-1:0] slew_select;
  logic [N-1:0] digital_enable_bits;
  logic [N-1:0] commit_enable_bits;
  logic         unlocked;
  logic         adc_prev;
  logic [GPMD_DATA_W-1:0] rdata;

  logic [N-1:0] pin_level;
  logic [N-1:0] pin_rise;
  logic [N-1:0] pin_fall;

  // Pin inputs pass through a synchroniser before any use.
  gpmd_pin_sync #(
    .WIDTH (N)
  ) u_sync (
    .REF_CLK_IN (REF_CLK_IN),
    .RESET_IN   (RESET_IN),
    .RAW_IN     (PIN_IN),
    .LEVEL_OUT  (pin_level),
    .RISE_OUT   (pin_rise),
    .FALL_OUT   (pin_fall)
  ); // RULE_23

  // Write decode.
  wire [N-1:0] wdata    = REG_WDATA_IN[N-1:0];
  wire         in_data_win =
    (REG_ADDR_IN[GPMD_ADDR_W-1:GPMD_MASK_MSB+1] == GPMD_DATA_WIN);
  wire         wr_data  = REG_WR_IN & in_data_win;
  wire [N-1:0] addr_msk = REG_ADDR_IN[GPMD_MASK_MSB:GPMD_MASK_LSB]; // RULE_06
  wire wr_dir   = REG_WR_IN & word_hit(REG_ADDR_IN, GPMD_OFF_DIR);
  wire wr_is    = REG_WR_IN & word_hit(REG_ADDR_IN, GPMD_OFF_IS);
  wire wr_ibe   = REG_WR_IN & word_hit(REG_ADDR_IN, GPMD_OFF_IBE);
  wire wr_iev   = REG_WR_IN & word_hit(REG_ADDR_IN, GPMD_OFF_IEV);
  wire wr_im    = REG_WR_IN & word_hit(REG_ADDR_IN, GPMD_OFF_IM);
  wire wr_icr   = REG_WR_IN & word_hit(REG_ADDR_IN, GPMD_OFF_ICR);
  wire wr_afsel = REG_WR_IN & word_hit(REG_ADDR_IN, GPMD_OFF_AFSEL);
  wire wr_dr2   = REG_WR_IN & word_hit(REG_ADDR_IN, GPMD_OFF_DR2);
  wire wr_dr4   = REG_WR_IN & word_hit(REG_ADDR_IN, GPMD_OFF_DR4);
  wire wr_dr8   = REG_WR_IN & word_hit(REG_ADDR_IN, GPMD_OFF_DR8);
  wire wr_odr   = REG_WR_IN & word_hit(REG_ADDR_IN, GPMD_OFF_ODR);
  wire wr_pur   = REG_WR_IN & word_hit(REG_ADDR_IN, GPMD_OFF_PUR);
  wire wr_pdr   = REG_WR_IN & word_hit(REG_ADDR_IN, GPMD_OFF_PDR);
  wire wr_slr   = REG_WR_IN & word_hit(REG_ADDR_IN, GPMD_OFF_SLR);
  wire wr_den   = REG_WR_IN & word_hit(REG_ADDR_IN, GPMD_OFF_DEN);
  wire wr_lock  = REG_WR_IN & word_hit(REG_ADDR_IN, GPMD_OFF_LOCK);
  wire wr_cr    = REG_WR_IN & word_hit(REG_ADDR_IN, GPMD_OFF_CR);

  // Inputs read back only where the pad's digital path is enabled.
  wire [N-1:0] pin_in_gated = pin_level & digital_enable_bits;

  // Input bits track the pin; output bits take masked writes.
  wire [N-1:0] data_write = wr_data ? addr_msk : '0; // RULE_07
  wire [N-1:0] next_data =
    (merge(masked_data_reg, wdata, data_write) & direction_bits) | // RULE_05
    (pin_in_gated & ~direction_bits); // RULE_04

  // Trigger condition per pin.
  wire [N-1:0] single_edge =
    (irq_polarity_select & pin_rise) | (~irq_polarity_select & pin_fall);
  wire [N-1:0] edge_hit =
    (irq_both_edge_select & (pin_rise | pin_fall)) | // RULE_22
    (~irq_both_edge_select & single_edge); // RULE_12
  wire [N-1:0] level_hit =
    (irq_polarity_select & pin_level) |
    (~irq_polarity_select & ~pin_level); // RULE_12
  wire [N-1:0] icr_bits  = wr_icr ? wdata : '0; // RULE_15
  wire [N-1:0] next_edge_latch =
    (edge_latch & ~icr_bits) | (edge_hit & ~irq_sense_select); // RULE_10

  // Level conditions are not stored; they show only while the pin holds.
  wire [N-1:0] raw_irq_state =
    (irq_sense_select & level_hit) |
    (~irq_sense_select & edge_latch); // RULE_14 RULE_11
  wire [N-1:0] masked_irq_state = raw_irq_state & irq_mask_bits; // RULE_13
  wire         adc_now = masked_irq_state[ADC_TRIG_BIT];

  // Protected alt-select bits need the unlock key and a set commit bit.
  wire [N-1:0] afsel_writable =
    commit_enable_bits & (~PROTECT_MASK | {N{unlocked}}); // RULE_19
  wire [N-1:0] cr_writable = unlocked ? PROTECT_MASK : '0;

  // Drive selections are exclusive: a write takes its bits from the others.
  wire [N-1:0] dr2_take = (wr_dr4 | wr_dr8) ? wdata : '0;
  wire [N-1:0] dr4_take = (wr_dr2 | wr_dr8) ? wdata : '0;
  wire [N-1:0] dr8_take = (wr_dr2 | wr_dr4) ? wdata : '0;

  // Pad steering: peripheral or data registers, then open-drain rule.
  wire [N-1:0] drive_val =
    (alt_function_select & ALT_OUT_IN) |
    (~alt_function_select & masked_data_reg); // RULE_18
  wire [N-1:0] drive_en =
    (alt_function_select & ALT_OE_IN) |
    (~alt_function_select & direction_bits); // RULE_05
  wire [N-1:0] next_pin_out = drive_val & ~open_drain_select;
  wire [N-1:0] next_pin_oe  = drive_en & digital_enable_bits &
                              (~open_drain_select | ~drive_val); // RULE_20

  // Read decode.
  wire rd_pid = (REG_ADDR_IN >= GPMD_OFF_PID0) &
                (REG_ADDR_IN < GPMD_OFF_CID0);
  wire rd_cid = (REG_ADDR_IN >= GPMD_OFF_CID0);
  wire [2:0] pid_idx = 3'(REG_ADDR_IN[GPMD_ADDR_W-1:2] -
                          GPMD_OFF_PID0[GPMD_ADDR_W-1:2]);
  wire [1:0] cid_idx = 2'(REG_ADDR_IN[GPMD_ADDR_W-1:2] -
                          GPMD_OFF_CID0[GPMD_ADDR_W-1:2]);
  wire [N-1:0] rd_byte =
    in_data_win ?
      (masked_data_reg & addr_msk) : // RULE_08
    word_hit(REG_ADDR_IN, GPMD_OFF_DIR)   ? direction_bits :
    word_hit(REG_ADDR_IN, GPMD_OFF_IS)    ? irq_sense_select :
    word_hit(REG_ADDR_IN, GPMD_OFF_IBE)   ? irq_both_edge_select :
    word_hit(REG_ADDR_IN, GPMD_OFF_IEV)   ? irq_polarity_select :
    word_hit(REG_ADDR_IN, GPMD_OFF_IM)    ? irq_mask_bits :
    word_hit(REG_ADDR_IN, GPMD_OFF_RIS)   ? raw_irq_state :
    word_hit(REG_ADDR_IN, GPMD_OFF_MIS)   ? masked_irq_state :
    word_hit(REG_ADDR_IN, GPMD_OFF_AFSEL) ? alt_function_select :
    word_hit(REG_ADDR_IN, GPMD_OFF_DR2)   ? drive_2ma_select :
    word_hit(REG_ADDR_IN, GPMD_OFF_DR4)   ? drive_4ma_select :
    word_hit(REG_ADDR_IN, GPMD_OFF_DR8)   ? drive_8ma_select :
    word_hit(REG_ADDR_IN, GPMD_OFF_ODR)   ? open_drain_select :
    word_hit(REG_ADDR_IN, GPMD_OFF_PUR)   ? pull_up_select :
    word_hit(REG_ADDR_IN, GPMD_OFF_PDR)   ? pull_down_select :
    word_hit(REG_ADDR_IN, GPMD_OFF_SLR)   ? slew_select :
    word_hit(REG_ADDR_IN, GPMD_OFF_DEN)   ? digital_enable_bits :
    word_hit(REG_ADDR_IN, GPMD_OFF_LOCK)  ? {{(N-1){1'b0}}, ~unlocked} :
    word_hit(REG_ADDR_IN, GPMD_OFF_CR)    ? commit_enable_bits :
    rd_pid ? GPMD_PERIPH_ID[pid_idx] : // RULE_21
    rd_cid ? GPMD_CELL_ID[cid_idx] :
    '0;
  wire [GPMD_DATA_W-1:0] next_rdata =
    REG_RD_IN ? {{PAD{1'b0}}, rd_byte} : '0;

  // Data, direction and read-data registers.
  always_ff @(posedge REF_CLK_IN)
  begin
    if (RESET_IN)
    begin
      masked_data_reg <= GPMD_RST_ZERO;
      direction_bits  <= GPMD_RST_ZERO;
      rdata           <= '0;
    end
    else
    begin
      masked_data_reg <= next_data;
      direction_bits  <= wr_dir ? wdata : direction_bits;
      rdata           <= next_rdata;
    end
  end

  // Interrupt configuration and latched edge state.
  always_ff @(posedge REF_CLK_IN)
  begin
    if (RESET_IN)
    begin
      irq_sense_select     <= GPMD_RST_ZERO;
      irq_both_edge_select <= GPMD_RST_ZERO;
      irq_polarity_select  <= GPMD_RST_ZERO;
      irq_mask_bits        <= GPMD_RST_ZERO;
      edge_latch           <= GPMD_RST_ZERO;
    end
    else
    begin
      irq_sense_select     <= wr_is  ? wdata : irq_sense_select;
      irq_both_edge_select <= wr_ibe ? wdata : irq_both_edge_select;
      irq_polarity_select  <= wr_iev ? wdata : irq_polarity_select;
      irq_mask_bits        <= wr_im  ? wdata : irq_mask_bits;
      edge_latch           <= next_edge_latch; // RULE_10
    end
  end

  // Mode, commit and lock state; protected pins wake in debug mode.
  always_ff @(posedge REF_CLK_IN)
  begin
    if (RESET_IN)
    begin
      alt_function_select <= PROTECT_MASK; // RULE_01 RULE_02 RULE_03
      digital_enable_bits <= PROTECT_MASK; // RULE_01 RULE_02
      pull_up_select      <= PROTECT_MASK; // RULE_01 RULE_02
      pull_down_select    <= GPMD_RST_ZERO; // RULE_01
      commit_enable_bits  <= ~PROTECT_MASK;
      unlocked            <= 1'b0;
    end
    else
    begin
      alt_function_select <= wr_afsel ?
        merge(alt_function_select, wdata, afsel_writable) :
        alt_function_select; // RULE_19
      digital_enable_bits <= wr_den ? wdata : digital_enable_bits;
      pull_up_select      <= wr_pur ? wdata : pull_up_select;
      pull_down_select    <= wr_pdr ? wdata : pull_down_select;
      commit_enable_bits  <= wr_cr ?
        merge(commit_enable_bits, wdata, cr_writable) :
        commit_enable_bits;
      unlocked            <= wr_lock ? (REG_WDATA_IN == LOCK_KEY) : unlocked;
    end
  end

  // Drive strength, open drain and slew settings.
  always_ff @(posedge REF_CLK_IN)
  begin
    if (RESET_IN)
    begin
      drive_2ma_select  <= GPMD_RST_ONES;
      drive_4ma_select  <= GPMD_RST_ZERO;
      drive_8ma_select  <= GPMD_RST_ZERO;
      open_drain_select <= GPMD_RST_ZERO;
      slew_select       <= GPMD_RST_ZERO;
    end
    else
    begin
      drive_2ma_select  <= wr_dr2 ? wdata : drive_2ma_select & ~dr2_take;
      drive_4ma_select  <= wr_dr4 ? wdata : drive_4ma_select & ~dr4_take;
      drive_8ma_select  <= wr_dr8 ? wdata : drive_8ma_select & ~dr8_take;
      open_drain_select <= wr_odr ? wdata : open_drain_select;
      slew_select       <= wr_slr ? wdata : slew_select;
    end
  end

  // Registered pad and interrupt outputs.
  always_ff @(posedge REF_CLK_IN)
  begin
    if (RESET_IN)
    begin
      PIN_OUT      <= GPMD_RST_ZERO;
      PIN_OE_OUT   <= GPMD_RST_ZERO; // RULE_01
      IRQ_OUT      <= 1'b0;
      ADC_TRIG_OUT <= 1'b0;
      adc_prev     <= 1'b0;
    end
    else
    begin
      PIN_OUT      <= next_pin_out; // RULE_05
      PIN_OE_OUT   <= next_pin_oe;
      IRQ_OUT      <= |masked_irq_state; // RULE_09
      ADC_TRIG_OUT <= adc_now & ~adc_prev; // RULE_16
      adc_prev     <= adc_now;
    end
  end

  // Pad control levels come straight from their registers.
  assign REG_RDATA_OUT  = rdata;
  assign ALT_IN_OUT     = pin_in_gated;
  assign PULL_UP_OUT    = pull_up_select; // RULE_20
  assign PULL_DOWN_OUT  = pull_down_select;
  assign DIGITAL_EN_OUT = digital_enable_bits;
  assign DRIVE_2MA_OUT  = drive_2ma_select;
  assign DRIVE_4MA_OUT  = drive_4ma_select;
  assign DRIVE_8MA_OUT  = drive_8ma_select;
  assign SLEW_CTRL_OUT  = slew_select;
  assign OPEN_DRAIN_OUT = open_drain_select;

endmodule

// File: sim/gpmd_pad_model.sv
`timescale 1ns/1ps
module gpmd_pad_model
(
  input  wire logic       clk_in,
  input  wire logic [7:0] pin_out_in,
  input  wire logic [7:0] pin_oe_in,
  input  wire logic [7:0] pull_up_in,
  input  wire logic [7:0] pull_down_in,
  input  wire logic [7:0] ext_val_in,
  input  wire logic [7:0] ext_en_in,
  output logic      [7:0] pin_out
);
  logic [7:0] last = 8'h00;

  // Remembers the pad level so that a floating pad can flip every cycle.
  always @(posedge clk_in)
    last <= pin_out;

  // The port's driver wins, then the outside source, then the pulls.
  always_comb
    for (int i = 0; i < 8; i++)
      pin_out[i] = pin_oe_in[i] ? pin_out_in[i] :
                   ext_en_in[i] ? ext_val_in[i] :
                   pull_up_in[i] ? 1'b1 :
                   pull_down_in[i] ? 1'b0 : ~last[i];
endmodule

// File: sim/gpmd_monitor.sv
`timescale 1ns/1ps
module gpmd_monitor
  import gpmd_pkg::*;
#(
  parameter logic [7:0]  PROTECT_MASK = GPMD_PROTECT_DEFAULT,
  parameter int unsigned ADC_TRIG_BIT = GPMD_ADC_TRIG_DEFAULT
)
(
  input wire logic        REF_CLK_IN,
  input wire logic        RESET_IN,
  input wire logic [11:0] REG_ADDR_IN,
  input wire logic [31:0] REG_WDATA_IN,
  input wire logic        REG_WR_IN,
  input wire logic        REG_RD_IN,
  input wire logic [31:0] REG_RDATA_OUT,
  input wire logic [7:0]  PIN_OE_OUT,
  input wire logic [7:0]  PULL_UP_OUT,
  input wire logic [7:0]  PULL_DOWN_OUT,
  input wire logic [7:0]  DIGITAL_EN_OUT,
  input wire logic [7:0]  DRIVE_2MA_OUT,
  input wire logic [7:0]  DRIVE_4MA_OUT,
  input wire logic [7:0]  DRIVE_8MA_OUT,
  input wire logic        IRQ_OUT,
  input wire logic        ADC_TRIG_OUT
);
  logic [7:0] dir_sh;
  logic [7:0] im_sh;

  // Shadows direction and mask so reads and the interrupt can be judged.
  always_ff @(posedge REF_CLK_IN)
  begin
    if (RESET_IN)
    begin
      dir_sh <= 8'h00;
      im_sh  <= 8'h00;
    end
    else if (REG_WR_IN && REG_ADDR_IN == GPMD_OFF_DIR)
      dir_sh <= REG_WDATA_IN[7:0];
    else if (REG_WR_IN && REG_ADDR_IN == GPMD_OFF_IM)
      im_sh <= REG_WDATA_IN[7:0];
  end

  default clocking cb @(posedge REF_CLK_IN); endclocking
  default disable iff (RESET_IN);

  // Read requests of interest.
  sequence s_rd_data;
    REG_RD_IN && REG_ADDR_IN[11:10] == 2'h0;
  endsequence
  sequence s_rd_dir;
    REG_RD_IN && REG_ADDR_IN == GPMD_OFF_DIR;
  endsequence
  sequence s_rd_pid;
    REG_RD_IN && REG_ADDR_IN == GPMD_OFF_PID0;
  endsequence

  a_reset_pads: assert property ($past(RESET_IN) |->
    PIN_OE_OUT == 8'h00 && PULL_DOWN_OUT == 8'h00 &&
    PULL_UP_OUT == PROTECT_MASK && DIGITAL_EN_OUT == PROTECT_MASK)
    else $error("pad setup wrong after reset");
  a_data_rdmask: assert property (s_rd_data |=>
    (REG_RDATA_OUT[7:0] & ~$past(REG_ADDR_IN[9:2])) == 8'h00 &&
    REG_RDATA_OUT[31:8] == 24'h0) else $error("masked data bit read as one");
  a_dir_echo: assert property (s_rd_dir |=>
    REG_RDATA_OUT == {24'h0, $past(dir_sh)}) else $error("direction readback");
  a_ident_read: assert property (s_rd_pid |=>
    REG_RDATA_OUT == {24'h0, GPMD_PERIPH_ID[0]}) else $error("ident value");
  a_mask_gate: assert property (im_sh == 8'h00 |=> !IRQ_OUT)
    else $error("interrupt with all pins masked");
  a_adc_pulse: assert property (ADC_TRIG_OUT |=> !ADC_TRIG_OUT)
    else $error("trigger longer than one cycle");
  a_adc_irq: assert property (ADC_TRIG_OUT |->
    IRQ_OUT && $past(im_sh[ADC_TRIG_BIT])) else $error("trigger while masked");
  a_drive_excl: assert property (
    (DRIVE_2MA_OUT & DRIVE_4MA_OUT) == 8'h00 &&
    (DRIVE_8MA_OUT & (DRIVE_2MA_OUT | DRIVE_4MA_OUT)) == 8'h00)
    else $error("two drive strengths on one pin");
endmodule

bind gpmd_port gpmd_monitor #(.PROTECT_MASK(PROTECT_MASK),
  .ADC_TRIG_BIT(ADC_TRIG_BIT)) i_mon (.REF_CLK_IN, .RESET_IN, .REG_ADDR_IN,
  .REG_WDATA_IN, .REG_WR_IN, .REG_RD_IN, .REG_RDATA_OUT, .PIN_OE_OUT,
  .PULL_UP_OUT, .PULL_DOWN_OUT, .DIGITAL_EN_OUT, .DRIVE_2MA_OUT,
  .DRIVE_4MA_OUT, .DRIVE_8MA_OUT, .IRQ_OUT, .ADC_TRIG_OUT);

// File: sim/tb.sv
`timescale 1ns/1ps
module tb
  import gpmd_pkg::*;
();
  logic        clk = 1'b0;
  logic        rst = 1'b1;
  logic [11:0] addr = 12'h000;
  logic [31:0] wd = 32'h0;
  logic        wr = 1'b0;
  logic        rd = 1'b0;
  logic [7:0]  ext = 8'h00;
  logic [7:0]  alt_o = 8'h00;
  logic [7:0]  alt_e = 8'h00;
  logic [31:0] rdata;
  logic [7:0]  alt_i;
  logic [7:0]  pin_i, pin_o, pin_e, pu, pd, den, dr2, dr4, dr8, slr, odr;
  logic        irq, adc;
  int          n_fail = 0;
  int          n_tests = 0;
  int          cyc = 0;
  int          adc_n = 0;

  always #5 clk = ~clk;

  gpmd_port i_dut (.REF_CLK_IN(clk), .RESET_IN(rst), .REG_ADDR_IN(addr),
    .REG_WDATA_IN(wd), .REG_WR_IN(wr), .REG_RD_IN(rd), .REG_RDATA_OUT(rdata),
    .PIN_IN(pin_i), .PIN_OUT(pin_o), .PIN_OE_OUT(pin_e), .ALT_OUT_IN(alt_o),
    .ALT_OE_IN(alt_e), .ALT_IN_OUT(alt_i), .PULL_UP_OUT(pu),
    .PULL_DOWN_OUT(pd), .DIGITAL_EN_OUT(den), .DRIVE_2MA_OUT(dr2),
    .DRIVE_4MA_OUT(dr4), .DRIVE_8MA_OUT(dr8), .SLEW_CTRL_OUT(slr),
    .OPEN_DRAIN_OUT(odr), .IRQ_OUT(irq), .ADC_TRIG_OUT(adc));

  gpmd_pad_model i_pad (.clk_in(clk), .pin_out_in(pin_o), .pin_oe_in(pin_e),
    .pull_up_in(pu), .pull_down_in(pd), .ext_val_in(ext),
    .ext_en_in(8'hFF), .pin_out(pin_i));

  // Hang guard and tally of trigger pulses.
  always @(posedge clk)
  begin
    cyc <= cyc + 1;
    if (adc === 1'b1)
      adc_n <= adc_n + 1;
    if (cyc == 3000)
    begin
      n_fail++;
      results();
    end
  end

  // Compares one value and reports a mismatch.
  task automatic chk(input logic [31:0] got, input logic [31:0] exp,
                     input string nm);
    n_tests++;
    if (got !== exp)
    begin
      n_fail++;
      $display("[FAIL] %s expected %h seen %h", nm, exp, got);
    end
  endtask

  // One-cycle register write.
  task automatic wrr(input logic [11:0] a, input logic [31:0] d);
    @(posedge clk);
    wr <= 1'b1;
    addr <= a;
    wd <= d;
    @(posedge clk);
    wr <= 1'b0;
  endtask

  // One-cycle register read; data is checked in the following cycle.
  task automatic rdc(input logic [11:0] a, input logic [31:0] e,
                     input string nm);
    @(posedge clk);
    rd <= 1'b1;
    addr <= a;
    @(posedge clk);
    rd <= 1'b0;
    #1 chk(rdata, e, nm);
    @(posedge clk);
  endtask

  task automatic tick(input int n);
    repeat (n) @(posedge clk);
  endtask

  // Prints the tally and the verdict, then stops.
  task automatic results();
    $display("Comparisons %0d mismatches %0d", n_tests, n_fail);
    if (n_fail == 0 && n_tests > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask

  // Main sequence of register and pin scenarios.
  initial
  begin
    tick(4);
    rst <= 1'b0;
    rdc(GPMD_OFF_AFSEL, 32'h80, "afsel");
    rdc(GPMD_OFF_DEN, 32'h80, "den");
    rdc(GPMD_OFF_PUR, 32'h80, "pur");
    rdc(GPMD_OFF_PDR, 32'h00, "pdr");
    rdc(GPMD_OFF_CR, 32'h7F, "commit");
    rdc(12'h600, 32'h0, "unmapped");
    for (int i = 0; i < 8; i++)
      rdc(GPMD_OFF_PID0 + 12'(4*i), 32'(GPMD_PERIPH_ID[i]), "pid");
    for (int i = 0; i < 4; i++)
      rdc(GPMD_OFF_CID0 + 12'(4*i), 32'(GPMD_CELL_ID[i]), "cid");
    wrr(GPMD_OFF_DEN, 32'hFF);
    wrr(GPMD_OFF_DIR, 32'hFF);
    rdc(GPMD_OFF_DIR, 32'hFF, "dir");
    wrr(12'h3FC, 32'h00);
    wrr(12'h098, 32'hEB);
    rdc(12'h3FC, 32'h22, "data write mask");
    rdc(12'h0C4, 32'h20, "data read mask");
    tick(2);
    chk(pin_o, 8'h22, "pin out");
    chk(pin_e, 8'h7F, "pin oe");
    wrr(GPMD_OFF_DIR, 32'h00);
    ext <= 8'hA5;
    tick(4);
    rdc(12'h1FC, 32'h25, "data in");
    chk(alt_i, 8'hA5, "alt in");
    wrr(GPMD_OFF_IEV, 32'h10);
    wrr(GPMD_OFF_ICR, 32'hFF);
    wrr(GPMD_OFF_IM, 32'h10);
    ext <= 8'hB5;
    tick(6);
    chk(irq, 1'b1, "irq edge");
    chk(adc_n, 1, "adc pulse");
    rdc(GPMD_OFF_RIS, 32'h10, "raw");
    rdc(GPMD_OFF_MIS, 32'h10, "masked");
    ext <= 8'hA5;
    tick(3);
    ext <= 8'hB5;
    tick(6);
    chk(adc_n, 1, "no retrigger");
    wrr(GPMD_OFF_ICR, 32'h00);
    tick(3);
    chk(irq, 1'b1, "clear zero");
    wrr(GPMD_OFF_ICR, 32'h10);
    tick(3);
    chk(irq, 1'b0, "clear one");
    wrr(GPMD_OFF_IM, 32'h00);
    wrr(GPMD_OFF_IBE, 32'h10);
    wrr(GPMD_OFF_ICR, 32'hFF);
    wrr(GPMD_OFF_IM, 32'h10);
    ext <= 8'hA5;
    tick(6);
    rdc(GPMD_OFF_RIS, 32'h10, "both edges");
    chk(adc_n, 2, "adc again");
    wrr(GPMD_OFF_IM, 32'h00);
    wrr(GPMD_OFF_IS, 32'h10);
    wrr(GPMD_OFF_IBE, 32'h00);
    wrr(GPMD_OFF_IEV, 32'h00);
    tick(3);
    rdc(GPMD_OFF_RIS, 32'h10, "level raw");
    rdc(GPMD_OFF_MIS, 32'h00, "level masked");
    chk(irq, 1'b0, "level gated");
    wrr(GPMD_OFF_IM, 32'h10);
    tick(3);
    chk(irq, 1'b1, "level irq");
    ext <= 8'hB5;
    tick(5);
    chk(irq, 1'b0, "level gone");
    wrr(GPMD_OFF_IM, 32'h00);
    wrr(GPMD_OFF_AFSEL, 32'h00);
    rdc(GPMD_OFF_AFSEL, 32'h80, "locked afsel");
    wrr(GPMD_OFF_LOCK, GPMD_LOCK_KEY_DEFAULT);
    wrr(GPMD_OFF_CR, 32'hFF);
    wrr(GPMD_OFF_AFSEL, 32'h01);
    rdc(GPMD_OFF_AFSEL, 32'h01, "open afsel");
    alt_o <= 8'h01;
    alt_e <= 8'h01;
    tick(3);
    chk(pin_e[0], 1'b1, "alt oe");
    chk(pin_o[0], 1'b1, "alt out");
    wrr(GPMD_OFF_PDR, 32'h0F);
    wrr(GPMD_OFF_ODR, 32'h30);
    wrr(GPMD_OFF_SLR, 32'hC0);
    wrr(GPMD_OFF_DR8, 32'h0F);
    #1;
    chk({pd, odr, slr, dr8}, 32'h0F30C00F, "pads");
    chk({dr4, dr2}, 32'h00F0, "drive 2ma 4ma");
    tick(1);
    rst <= 1'b1;
    tick(4);
    rst <= 1'b0;
    rdc(GPMD_OFF_AFSEL, 32'h80, "afsel again");
    rdc(GPMD_OFF_LOCK, 32'h1, "relocked");
    results();
  end
endmodule
